// ===== logic/regfile_pkg.sv
// constants and types shared by the frame-cached register file
package regfile_pkg;

	localparam int unsigned WORD_W       = 32;
	localparam int unsigned EXT_W        = 80;
	localparam int unsigned NUM_SHARED   = 16;
	localparam int unsigned NUM_LOCAL    = 16;
	localparam int unsigned NUM_EXT      = 4;
	localparam int unsigned NUM_FRAMES   = 4;
	localparam int unsigned MAX_LOADS    = 3;
	localparam int unsigned REG_ADDR_W   = 5;
	localparam int unsigned EXT_ADDR_W   = 2;
	localparam int unsigned SLOT_W       = 2;
	localparam int unsigned LDCNT_W      = 2;
	localparam int unsigned FP_REG_IDX   = 15;
	// bytes per frame on the memory procedure stack
	localparam logic [31:0] FRAME_BYTES  = 32'h0000_0040;
	localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
	localparam logic [3:0]  LAST_WORD    = 4'h0f;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
	localparam logic [79:0] EXT_RESET    = 80'h0000_0000_0000_0000_0000;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_SPILL  = 3'b010,
		ST_FILL   = 3'b100
	} frame_state_t;

endpackage : regfile_pkg

// ===== logic/load_scoreboard.sv
// pending-load scoreboard over the 32 general registers
`timescale 1ns/1ps
`default_nettype none
module load_scoreboard (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        set_valid,
	input  wire logic [4:0]  set_addr,
	input  wire logic        clr_valid,
	input  wire logic [4:0]  clr_addr,
	input  wire logic        flush,
	output logic      [31:0] busy_q,
	output logic      [1:0]  count_q
);
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [31:0] busy_d;
	logic [1:0]  count_d;

	assign set_vec = set_valid ? (32'h0000_0001 << set_addr) : 32'h0000_0000;
	assign clr_vec = clr_valid ? (32'h0000_0001 << clr_addr) : 32'h0000_0000;
	// set wins over a clear of the same register in the same cycle
	assign busy_d  = flush ? 32'h0000_0000 : ((busy_q & ~clr_vec) | set_vec); // [RL8] [RL9]
	assign count_d = flush ? 2'h0 :
		2'(count_q + {1'b0, set_valid} - {1'b0, clr_valid}); // [RL12]

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_q  <= 32'h0000_0000;
			count_q <= 2'h0;
		end else begin
			busy_q  <= busy_d;
			count_q <= count_d;
		end
	end
endmodule : load_scoreboard
`default_nettype wire

// ===== logic/frame_cached_register_file.sv
// general register file with four-frame local cache and load scoreboard
//
// Functional notes
// [RL1] 32 registers addressable: shared plus current locals
// [RL2] sixteen 32-bit shared, four 80-bit extended
// [RL3] calls and returns leave shared registers untouched
// [RL4] each call gets fresh sixteen local registers
// [RL5] cache holds four frames without memory traffic
// [RL6] overflowing call spills oldest frame to memory
// [RL7] shared register 15 is the frame pointer
// [RL8] issued load sets destination scoreboard bit
// [RL9] load data write clears scoreboard bit
// [RL10] reads of busy registers hold the instruction
// [RL11] independent instructions keep issuing during loads
// [RL12] up to three loads outstanding together
// [RL13] conditional instructions also use the scoreboard
// [RL14] result written and bypassed same cycle
// [RL15] fourth load stalls until one completes
// [RL16] return reloads spilled caller frame before resuming
`timescale 1ns/1ps
`default_nettype none
module frame_cached_register_file (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// issue side: register address 0..15 local, 16..31 shared
	input  wire logic        issue_valid,
	input  wire logic        issue_is_load,
	input  wire logic        issue_is_cond,
	input  wire logic        issue_rd_en,
	input  wire logic [4:0]  issue_dst,
	input  wire logic        issue_src_a_en,
	input  wire logic [4:0]  issue_src_a,
	input  wire logic        issue_src_b_en,
	input  wire logic [4:0]  issue_src_b,
	input  wire logic        call_req,
	input  wire logic        ret_req,
	// execution result and load return
	input  wire logic        res_valid,
	input  wire logic [4:0]  res_addr,
	input  wire logic [31:0] res_data,
	input  wire logic        ld_valid,
	input  wire logic [4:0]  ld_addr,
	input  wire logic [31:0] ld_data,
	input  wire logic        cond_done,
	input  wire logic [4:0]  cond_addr,
	// extended real registers
	input  wire logic        ext_we,
	input  wire logic [1:0]  ext_waddr,
	input  wire logic [79:0] ext_wdata,
	input  wire logic [1:0]  ext_raddr,
	// memory procedure stack port
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	output logic             issue_stall_q,
	output logic             frame_busy_q,
	output logic      [31:0] opnd_a_q,
	output logic      [31:0] opnd_b_q,
	output logic      [79:0] ext_rdata_q,
	output logic             mem_req_q,
	output logic             mem_we_q,
	output logic      [31:0] mem_addr_q,
	output logic      [31:0] mem_wdata_q,
	output logic      [1:0]  loads_pending_q
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [31:0] shared_q [regfile_pkg::NUM_SHARED];                          // [RL2]
	logic [79:0] ext_q [regfile_pkg::NUM_EXT];                                // [RL2]
	logic [31:0] local_q [regfile_pkg::NUM_FRAMES][regfile_pkg::NUM_LOCAL];   // [RL4] [RL5]

	regfile_pkg::frame_state_t state_q;
	regfile_pkg::frame_state_t state_d;
	logic [1:0]  cur_q;          // slot of the current frame
	logic [2:0]  cached_q;       // frames resident in cache, 1..4
	logic [31:0] depth_q;        // frames spilled to memory
	logic [3:0]  word_q;
	logic [1:0]  xfer_slot_q;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic [31:0] read_reg(input logic [4:0] a);
		read_reg = a[4] ? shared_q[a[3:0]] : local_q[cur_q][a[3:0]];       // [RL1]
	endfunction : read_reg

	function automatic logic hit(input logic en, input logic [4:0] a,
		input logic [31:0] busy);
		hit = en && busy[a];
	endfunction : hit

	logic [31:0] busy_vec;
	logic [31:0] cond_busy_q;
	logic [31:0] all_busy;
	logic [1:0]  ld_count;
	logic        hazard;
	logic        load_full;
	logic        flow_ok;
	logic        accept;
	logic        do_call;
	logic        do_ret;
	logic        need_spill;
	logic        need_fill;
	logic [1:0]  oldest_slot;
	logic [1:0]  caller_slot;
	logic [31:0] frame_ptr;
	logic        set_ld;
	logic        xfer_last;

	assign all_busy   = busy_vec | cond_busy_q;
	assign hazard     = hit(issue_src_a_en, issue_src_a, all_busy) |
		hit(issue_src_b_en, issue_src_b, all_busy) |
		hit(issue_rd_en, issue_dst, all_busy);                            // [RL10] [RL13]
	assign load_full  = issue_is_load && (ld_count == 2'(regfile_pkg::MAX_LOADS)) &&
		!ld_valid;                                                        // [RL15]
	assign flow_ok    = (state_q == regfile_pkg::ST_RUN);
	assign accept     = issue_valid && flow_ok && !hazard && !load_full;  // [RL11]
	assign do_call    = accept && call_req;
	assign do_ret     = accept && ret_req && !call_req;
	assign need_spill = do_call && (cached_q == 3'(regfile_pkg::NUM_FRAMES));  // [RL6]
	assign need_fill  = do_ret && (cached_q == 3'h1) && (depth_q != 32'h0000_0000); // [RL16]
	assign oldest_slot = 2'(cur_q + 2'h1);
	assign caller_slot = 2'(cur_q - 2'h1);
	assign frame_ptr  = shared_q[regfile_pkg::FP_REG_IDX];                // [RL7]
	assign set_ld     = accept && issue_is_load;
	assign xfer_last  = mem_ack && (word_q == regfile_pkg::LAST_WORD);

	load_scoreboard u_sb (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.set_valid (set_ld),
		.set_addr  (issue_dst),
		.clr_valid (ld_valid),
		.clr_addr  (ld_addr),
		.flush     (1'b0),
		.busy_q    (busy_vec),
		.count_q   (ld_count)
	);

	// ------------------------------------------------------------
	// frame controller
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			regfile_pkg::ST_RUN:   begin
				if (need_spill) state_d = regfile_pkg::ST_SPILL;
				else if (need_fill) state_d = regfile_pkg::ST_FILL;
			end
			regfile_pkg::ST_SPILL: if (xfer_last) state_d = regfile_pkg::ST_RUN;
			regfile_pkg::ST_FILL:  if (xfer_last) state_d = regfile_pkg::ST_RUN;
			default:               state_d = regfile_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= regfile_pkg::ST_RUN;
			cur_q       <= 2'h0;
			cached_q    <= 3'h1;
			depth_q     <= 32'h0000_0000;
			word_q      <= 4'h0;
			xfer_slot_q <= 2'h0;
		end else begin
			state_q <= state_d;
			if (do_call) begin
				cur_q <= 2'(cur_q + 2'h1);                                // [RL4]
				if (need_spill) begin
					xfer_slot_q <= oldest_slot;                           // [RL6]
					depth_q     <= depth_q + 32'h0000_0001;
				end else begin
					cached_q <= 3'(cached_q + 3'h1);                      // [RL5]
				end
			end else if (do_ret) begin
				cur_q <= caller_slot;
				if (need_fill) begin
					xfer_slot_q <= caller_slot;                           // [RL16]
					depth_q     <= depth_q - 32'h0000_0001;
				end else if (cached_q != 3'h1) begin
					cached_q <= 3'(cached_q - 3'h1);
				end
			end
			if (state_q != regfile_pkg::ST_RUN && mem_ack) begin
				word_q <= 4'(word_q + 4'h1);
			end
		end
	end

	// ------------------------------------------------------------
	// memory procedure stack port
	// ------------------------------------------------------------
	// stack address of the frame stored at the given depth
	function automatic logic [31:0] frame_addr(input logic [31:0] depth);
		frame_addr = frame_ptr + depth * regfile_pkg::FRAME_BYTES;           // [RL7]
	endfunction : frame_addr

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_addr_q  <= regfile_pkg::WORD_RESET;
			mem_wdata_q <= regfile_pkg::WORD_RESET;
		end else if (need_spill || need_fill) begin
			mem_req_q   <= 1'b1;
			mem_we_q    <= need_spill;
			mem_addr_q  <= need_spill ? frame_addr(depth_q) :
				frame_addr(depth_q - 32'h0000_0001);                        // [RL7]
			mem_wdata_q <= local_q[oldest_slot][0];
		end else if (mem_req_q && mem_ack) begin
			mem_req_q   <= !xfer_last;
			mem_addr_q  <= mem_addr_q + regfile_pkg::WORD_BYTES;
			mem_wdata_q <= local_q[xfer_slot_q][4'(word_q + 4'h1)];
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < regfile_pkg::NUM_SHARED; i++) begin
				shared_q[i] <= regfile_pkg::WORD_RESET;
			end
			for (int i = 0; i < regfile_pkg::NUM_EXT; i++) begin
				ext_q[i] <= regfile_pkg::EXT_RESET;
			end
			for (int f = 0; f < regfile_pkg::NUM_FRAMES; f++) begin
				for (int i = 0; i < regfile_pkg::NUM_LOCAL; i++) begin
					local_q[f][i] <= regfile_pkg::WORD_RESET;
				end
			end
		end else begin
			// shared registers only change on explicit writes, never on call or return
			if (res_valid && res_addr[4]) shared_q[res_addr[3:0]] <= res_data;  // [RL3] [RL14]
			if (ld_valid && ld_addr[4]) shared_q[ld_addr[3:0]] <= ld_data;      // [RL9]
			if (res_valid && !res_addr[4]) local_q[cur_q][res_addr[3:0]] <= res_data;
			if (ld_valid && !ld_addr[4]) local_q[cur_q][ld_addr[3:0]] <= ld_data;
			if (ext_we) ext_q[ext_waddr] <= ext_wdata;                          // [RL2]
			if (state_q == regfile_pkg::ST_FILL && mem_ack) begin
				local_q[xfer_slot_q][word_q] <= mem_rdata;                      // [RL16]
			end
		end
	end

	// ------------------------------------------------------------
	// conditional pending bits and outputs
	// ------------------------------------------------------------
	logic [31:0] cond_set;
	logic [31:0] cond_clr;
	assign cond_set = (accept && issue_is_cond && issue_rd_en) ?
		(32'h0000_0001 << issue_dst) : 32'h0000_0000;
	assign cond_clr = cond_done ? (32'h0000_0001 << cond_addr) : 32'h0000_0000;

	// bypass: a result landing this cycle feeds the operand directly
	function automatic logic [31:0] operand(input logic [4:0] a);
		operand = (res_valid && res_addr == a) ? res_data : read_reg(a);    // [RL14]
	endfunction : operand

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cond_busy_q     <= 32'h0000_0000;
			issue_stall_q   <= 1'b0;
			frame_busy_q    <= 1'b0;
			opnd_a_q        <= regfile_pkg::WORD_RESET;
			opnd_b_q        <= regfile_pkg::WORD_RESET;
			ext_rdata_q     <= regfile_pkg::EXT_RESET;
			loads_pending_q <= 2'h0;
		end else begin
			cond_busy_q     <= (cond_busy_q & ~cond_clr) | cond_set;            // [RL13]
			issue_stall_q   <= issue_valid && !accept;                          // [RL10] [RL15]
			frame_busy_q    <= state_d != regfile_pkg::ST_RUN;
			opnd_a_q        <= operand(issue_src_a);
			opnd_b_q        <= operand(issue_src_b);
			ext_rdata_q     <= ext_q[ext_raddr];
			loads_pending_q <= ld_count;                                        // [RL12]
		end
	end
endmodule : frame_cached_register_file
`default_nettype wire

// ===== test/stack_mem_model.sv
// stack memory model answering the spill and fill port
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        mem_req_q,
	input  wire logic        mem_we_q,
	input  wire logic        slow,
	input  wire logic [31:0] mem_addr_q,
	input  wire logic [31:0] mem_wdata_q,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] words [0:255];
	logic        phase_q;
	// slow mode acks every other cycle; idle data inverts so it is never stale
	always_ff @(negedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack   <= 1'b0;
			phase_q   <= 1'b0;
			mem_rdata <= 32'h0000_0000;
		end else begin
			phase_q   <= ~phase_q;
			mem_ack   <= mem_req_q && (!slow || phase_q);
			mem_rdata <= (mem_req_q && !mem_we_q) ? words[mem_addr_q[9:2]] : ~mem_rdata;
		end
	end
	always_ff @(posedge core_clk) begin
		if (mem_req_q && mem_ack && mem_we_q) words[mem_addr_q[9:2]] <= mem_wdata_q;
	end
endmodule : stack_mem_model
`default_nettype wire

// ===== test/regfile_asserts.sv
// port assertions for the frame-cached register file
`timescale 1ns/1ps
`default_nettype none
module regfile_asserts (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        issue_valid,
	input wire logic        issue_is_load,
	input wire logic        res_valid,
	input wire logic        ld_valid,
	input wire logic        mem_ack,
	input wire logic        issue_stall_q,
	input wire logic        frame_busy_q,
	input wire logic        mem_req_q,
	input wire logic        mem_we_q,
	input wire logic [4:0]  res_addr,
	input wire logic [4:0]  issue_src_a,
	input wire logic [4:0]  issue_src_b,
	input wire logic [31:0] res_data,
	input wire logic [31:0] opnd_a_q,
	input wire logic [31:0] opnd_b_q,
	input wire logic [31:0] mem_addr_q,
	input wire logic [1:0]  loads_pending_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence s_ack_run;
		mem_req_q && mem_ack ##1 mem_req_q;
	endsequence
	sequence s_ld_taken;
		issue_valid && issue_is_load && !ld_valid ##1 !issue_stall_q;
	endsequence
	sequence s_ld_back;
		ld_valid && !issue_valid ##1 loads_pending_q != 2'h0;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_addr_step;
		s_ack_run |-> mem_addr_q == $past(mem_addr_q) + 32'h0000_0004;
	endproperty
	property p_req_hold;
		mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q);
	endproperty
	property p_busy_stall;
		frame_busy_q && issue_valid && !mem_ack |=> issue_stall_q;
	endproperty
	property p_byp_a;
		res_valid && res_addr[4] && issue_src_a == res_addr && !ld_valid
			|=> opnd_a_q == $past(res_data);
	endproperty
	property p_byp_b;
		res_valid && res_addr[4] && issue_src_b == res_addr && !ld_valid
			|=> opnd_b_q == $past(res_data);
	endproperty
	property p_ld_inc;
		s_ld_taken |=> loads_pending_q == $past(loads_pending_q) + 2'h1;
	endproperty
	property p_ld_dec;
		s_ld_back |=> loads_pending_q == $past(loads_pending_q) - 2'h1;
	endproperty
	property p_ld_full;
		loads_pending_q == 2'h3 && !$past(ld_valid) && issue_valid && issue_is_load && !ld_valid
			|=> issue_stall_q;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("stack address step wrong");
	a_req_hold: assert property (p_req_hold) else $error("stack request changed early");
	a_busy_stall: assert property (p_busy_stall) else $error("issue taken in frame move");
	a_byp_a: assert property (p_byp_a) else $error("bypass a wrong");
	a_byp_b: assert property (p_byp_b) else $error("bypass b wrong");
	a_ld_inc: assert property (p_ld_inc) else $error("load count did not rise");
	a_ld_dec: assert property (p_ld_dec) else $error("load count did not fall");
	a_ld_full: assert property (p_ld_full) else $error("fourth load not held");
endmodule : regfile_asserts
bind frame_cached_register_file regfile_asserts i_chk (.core_clk, .resetn, .issue_valid,
	.issue_is_load, .res_valid, .ld_valid, .mem_ack, .issue_stall_q, .frame_busy_q, .mem_req_q,
	.mem_we_q, .res_addr, .issue_src_a, .issue_src_b, .res_data, .opnd_a_q, .opnd_b_q,
	.mem_addr_q, .loads_pending_q);
`default_nettype wire

// ===== test/tb_frame_cached_register_file.sv
// self-checking bench for the frame-cached register file
`timescale 1ns/1ps
`default_nettype none
module tb_frame_cached_register_file;
	localparam logic [3:0] K_LD = 4'h8, K_CD = 4'h4, K_CL = 4'h2, K_RT = 4'h1, K_RD = 4'h0;
	logic        core_clk = 0, resetn = 0, slow = 0, issue_valid = 0, issue_is_load = 0;
	logic        issue_is_cond = 0, issue_rd_en = 0, issue_src_a_en = 1, issue_src_b_en = 1;
	logic        call_req = 0, ret_req = 0, res_valid = 0, ld_valid = 0, cond_done = 0, ext_we = 0;
	logic [4:0]  issue_dst = 0, issue_src_a = 0, issue_src_b = 0, res_addr = 0, ld_addr = 0, cond_addr = 0;
	logic [31:0] res_data = 0, ld_data = 0, a_log [0:39], d_log [0:39];
	logic [1:0]  ext_waddr = 0, ext_raddr = 0;
	logic [79:0] ext_wdata = 80'h0123_4567_89ab_cdef_0011;
	logic        w_log [0:39];
	wire         mem_ack, issue_stall_q, frame_busy_q, mem_req_q, mem_we_q;
	wire  [31:0] mem_rdata, opnd_a_q, opnd_b_q, mem_addr_q, mem_wdata_q;
	wire  [79:0] ext_rdata_q;
	wire  [1:0]  loads_pending_q;
	int          n_errors = 0, compares = 0, n_mem = 0;
	frame_cached_register_file i_dut (.*);
	stack_mem_model i_mem (.*);
	initial forever #2.5 core_clk = ~core_clk;
	// log of the first 40 stack words moved
	always @(posedge core_clk) begin
		if (mem_req_q && mem_ack && n_mem < 40) begin
			a_log[n_mem] <= mem_addr_q;
			d_log[n_mem] <= mem_we_q ? mem_wdata_q : mem_rdata;
			w_log[n_mem] <= mem_we_q;
			n_mem <= n_mem + 1;
		end
	end
	task automatic chk(input logic [79:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic quiet;
		{issue_valid, res_valid, ld_valid, cond_done, ext_we} = 5'h00;
		@(negedge core_clk);
	endtask : quiet
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		{res_valid, res_addr, res_data} = {1'b1, a, d};
		@(negedge core_clk);
	endtask : wr
	// offer one instruction, retried while refused, up to tries cycles
	task automatic iss(input logic [3:0] kind, input logic [4:0] dst, sa, sb, input int tries,
			output logic st);
		{issue_is_load, issue_is_cond, call_req, ret_req} = kind;
		{issue_dst, issue_src_a, issue_src_b} = {dst, sa, sb};
		issue_rd_en = kind[3] | kind[2];
		issue_valid = 1'b1;
		st = 1'b1;
		for (int i = 0; i < tries && st !== 1'b0; i++) begin
			@(posedge core_clk);
			@(negedge core_clk);
			st = issue_stall_q;
		end
		if (tries > 1 && st !== 1'b0) begin
			n_errors++;
			end_of_test();
		end
	endtask : iss
	task automatic t_shared;
		logic st;
		wr(5'h13, 32'hcafe_0013);
		wr(5'h03, 32'h1111_0003);
		{ext_we, ext_waddr, ext_raddr} = {1'b1, 2'h2, 2'h2};
		@(negedge core_clk);
		quiet();
		iss(K_RD, 5'h00, 5'h13, 5'h03, 1, st);
		chk(st, 1'b0);
		chk(opnd_a_q, 32'hcafe_0013);
		chk(opnd_b_q, 32'h1111_0003);
		chk(ext_rdata_q, ext_wdata);
		iss(K_CL, 5'h00, 5'h08, 5'h09, 200, st);
		{res_valid, res_addr, res_data} = {1'b1, 5'h13, 32'hbeef_0013};
		iss(K_RD, 5'h00, 5'h13, 5'h13, 1, st);
		chk(opnd_a_q, 32'hbeef_0013);
		chk(opnd_b_q, 32'hbeef_0013);
		chk(ext_rdata_q, ext_wdata);
		quiet();
		// callee sees its own untouched local set, not the caller's
		iss(K_RD, 5'h00, 5'h03, 5'h13, 1, st);
		chk(opnd_a_q, 32'h0000_0000);
		chk(opnd_b_q, 32'hbeef_0013);
		iss(K_RT, 5'h00, 5'h08, 5'h09, 200, st);
		iss(K_RD, 5'h00, 5'h03, 5'h13, 1, st);
		chk(opnd_a_q, 32'h1111_0003);
		chk(opnd_b_q, 32'hbeef_0013);
		chk(n_mem, 0);
		quiet();
		$display("t_shared done");
	endtask : t_shared
	task automatic t_score;
		logic st;
		for (int k = 1; k <= 3; k++) begin
			iss(K_LD, 5'(k), 5'h08, 5'h09, 1, st);
			chk(st, 1'b0);
		end
		iss(K_RD, 5'h00, 5'h04, 5'h05, 1, st);
		chk(st, 1'b0);
		chk(loads_pending_q, 2'h3);
		iss(K_LD, 5'h06, 5'h08, 5'h09, 1, st);
		chk(st, 1'b1);
		iss(K_RD, 5'h00, 5'h01, 5'h04, 1, st);
		chk(st, 1'b1);
		quiet();
		for (int k = 1; k <= 3; k++) begin
			{ld_valid, ld_addr, ld_data} = {1'b1, 5'(k), 32'h00d0_0000 + k};
			@(negedge core_clk);
		end
		quiet();
		iss(K_RD, 5'h00, 5'h01, 5'h03, 1, st);
		chk(st, 1'b0);
		chk(opnd_a_q, 32'h00d0_0001);
		chk(opnd_b_q, 32'h00d0_0003);
		chk(loads_pending_q, 2'h0);
		iss(K_CD, 5'h07, 5'h08, 5'h09, 1, st);
		iss(K_RD, 5'h00, 5'h07, 5'h08, 1, st);
		chk(st, 1'b1);
		quiet();
		{cond_done, cond_addr} = {1'b1, 5'h07};
		@(negedge core_clk);
		cond_done = 1'b0;
		iss(K_RD, 5'h00, 5'h07, 5'h08, 1, st);
		chk(st, 1'b0);
		quiet();
		$display("t_score done");
	endtask : t_score
	task automatic t_spill;
		logic st;
		wr(5'h1f, 32'h0000_1000);
		wr(5'h00, 32'h5a5a_0000);
		// stop the result write so the filled word is what gets read back
		quiet();
		for (int k = 0; k < 4; k++) begin
			if (k == 3) chk(n_mem, 0);
			iss(K_CL, 5'h00, 5'h08, 5'h09, 200, st);
		end
		iss(K_RD, 5'h00, 5'h1f, 5'h1f, 200, st);
		chk(opnd_a_q, 32'h0000_1000);
		chk(n_mem, 16);
		chk(a_log[0], 32'h0000_1000);
		chk(a_log[15], 32'h0000_103c);
		chk(w_log[0], 1'b1);
		chk(d_log[0], 32'h5a5a_0000);
		slow = 1'b1;
		for (int k = 0; k < 4; k++) iss(K_RT, 5'h00, 5'h08, 5'h09, 200, st);
		iss(K_RD, 5'h00, 5'h00, 5'h1f, 200, st);
		chk(opnd_a_q, 32'h5a5a_0000);
		chk(n_mem, 32);
		chk(a_log[16], 32'h0000_1000);
		chk(w_log[16], 1'b0);
		chk(d_log[16], 32'h5a5a_0000);
		quiet();
		$display("t_spill done");
	endtask : t_spill
	initial begin
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		chk({issue_stall_q, frame_busy_q, mem_req_q, loads_pending_q}, 5'h00);
		t_shared();
		t_score();
		t_spill();
		end_of_test();
	end
	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end
endmodule : tb_frame_cached_register_file
`default_nettype wire
